/* pkg/mac_slice_defines.vh */
`ifndef MAC_SLICE_DEFINES_VH
`define MAC_SLICE_DEFINES_VH

// Register byte offsets
`define OFS_CTRL      12'h000
`define OFS_STATUS    12'h004
`define OFS_CLEAR     12'h008
`define OFS_IRQ_EN    12'h00c
`define OFS_CAPACITY  12'h010
`define OFS_RES_LO    12'h014
`define OFS_RES_HI    12'h018
`define OFS_LIVE      12'h01c

// Control register fields
`define CTRL_FUNC_LSB   0
`define CTRL_FUNC_MSB   1
`define CTRL_WIDTH_LSB  2
`define CTRL_WIDTH_MSB  3
`define CTRL_SIGNED     4
`define CTRL_IN_REG     5
`define CTRL_PIPE_REG   6
`define CTRL_SHIFT      7
`define CTRL_SUB        8
`define CTRL_W          9
`define CTRL_RESET      9'h000

// Function element codes
`define FN_PRODUCT    2'h0
`define FN_ACCUM      2'h1
`define FN_SUM_PROD   2'h2
`define FN_SUM_ACCUM  2'h3

// Operand width codes
`define WD_9          2'h0
`define WD_18         2'h1
`define WD_36         2'h2

// Status and interrupt bits
`define ST_OVERFLOW   0
`define ST_CFG_ERR    1
`define ST_ACC_LOAD   2
`define ST_W          3

// Elements per block, widths 9/18/36
`define CAP_PRODUCT   12'h841
`define CAP_ACCUM     12'h220
`define CAP_SUM_PROD  12'h420
`define CAP_SUM_ACCUM 12'h210

// Datapath sizes
`define OPND_W        36
`define PROD_W        72
`define ACC_W         52

`endif

/* hw/mac_product_lane.v */
`timescale 1ns/100ps
`default_nettype none
`include "mac_slice_defines.vh"

module mac_product_lane #(
	parameter OPND_W = `OPND_W,
	parameter PROD_W = `PROD_W
) (
	// Configuration
	input  wire [1:0]        width_sel_in,
	input  wire              signed_in,
	// Operands
	input  wire [OPND_W-1:0] opa_in,
	input  wire [OPND_W-1:0] opb_in,
	// Product
	output wire [PROD_W-1:0] prod_out
);

	// Keep only the active width, extend per signedness
	function [OPND_W:0] trim;
		input [OPND_W-1:0] v;
		input [1:0]        w;
		input              s;
		begin
			if (w == `WD_9)
				trim = {{(OPND_W-8){s & v[8]}}, v[8:0]};
			else if (w == `WD_18)
				trim = {{(OPND_W-17){s & v[17]}}, v[17:0]};
			else
				trim = {s & v[OPND_W-1], v};
		end
	endfunction

	wire signed [OPND_W:0]     a_x;
	wire signed [OPND_W:0]     b_x;
	wire signed [2*OPND_W+1:0] full;

	assign a_x      = trim(opa_in, width_sel_in, signed_in);
	assign b_x      = trim(opb_in, width_sel_in, signed_in);
	assign full     = a_x * b_x;
	assign prod_out = full[PROD_W-1:0];

endmodule
`default_nettype wire

/* hw/mac_slice.v */
// Operation
// - The block offers product elements at 9, 18 or 36 bits and accumulate, sum of products and summed accumulate elements at 9 or 18 bits.
// - All operands of one element are either all signed or all unsigned.
// - One operand width applies to every element of the block.
// - Element counts per block are 8/4/1 product, 2/2/0 accumulate, 4/2/0 sum of products, 2/1/0 summed accumulate.
// - Each operand register loads from its input or shifts from the preceding operand register.
// - The accumulate element adds A times B to the previous total and presents the new total.
// - Input and pipeline registers are optional while the output register always holds the total.
// - The accumulator takes an initial value at run time under a user signal.
// - The overflow indication is registered and updates with the accumulator output.
// - Elements chain to one another for wider or parallel structures.
`timescale 1ns/100ps
`default_nettype none
`include "mac_slice_defines.vh"

module mac_slice #(
	parameter OPND_W = `OPND_W,
	parameter PROD_W = `PROD_W,
	parameter ACC_W  = `ACC_W
) (
	// Clock, reset, enable
	input  wire              clk_sys_in,
	input  wire              srst_in,
	input  wire              ce_in,
	// AHB-Lite slave
	input  wire              hsel_in,
	input  wire [31:0]       haddr_in,
	input  wire [1:0]        htrans_in,
	input  wire              hwrite_in,
	input  wire [2:0]        hsize_in,
	input  wire [31:0]       hwdata_in,
	input  wire              hready_in,
	output reg  [31:0]       hrdata_out,
	output wire              hreadyout_out,
	output wire              hresp_out,
	// Operands
	input  wire [OPND_W-1:0] opa0_in,
	input  wire [OPND_W-1:0] opb0_in,
	input  wire [OPND_W-1:0] opa1_in,
	input  wire [OPND_W-1:0] opb1_in,
	// Accumulator load
	input  wire              acc_load_in,
	input  wire [ACC_W-1:0]  acc_init_in,
	// Chain in
	input  wire [OPND_W-1:0] chain_a_in,
	input  wire [OPND_W-1:0] chain_b_in,
	input  wire [PROD_W-1:0] chain_sum_in,
	// Chain out
	output wire [OPND_W-1:0] chain_a_out,
	output wire [OPND_W-1:0] chain_b_out,
	output wire [PROD_W-1:0] chain_sum_out,
	// Results
	output wire [PROD_W-1:0] result_out,
	output wire              overflow_out,
	output wire              irq_out
);

	localparam SUM_W = ACC_W + 2;

	// Elements per block for a function, nibbles for widths 9/18/36 from the top
	function [11:0] capacity;
		input [1:0] fn;
		begin
			if (fn == `FN_PRODUCT)
				capacity = `CAP_PRODUCT;
			else if (fn == `FN_ACCUM)
				capacity = `CAP_ACCUM;
			else if (fn == `FN_SUM_PROD)
				capacity = `CAP_SUM_PROD;
			else
				capacity = `CAP_SUM_ACCUM;
		end
	endfunction

	// Count of elements at a width, zero where not offered
	function [3:0] count_at;
		input [1:0] fn;
		input [1:0] wd;
		reg   [11:0] c;
		begin
			c = capacity(fn);
			if (wd == `WD_9)
				count_at = c[11:8];
			else if (wd == `WD_18)
				count_at = c[7:4];
			else if (wd == `WD_36)
				count_at = c[3:0];
			else
				count_at = 4'h0;
		end
	endfunction

	// Bus state
	reg        ph_valid_r;
	reg        ph_write_r;
	reg [11:0] ph_addr_r;
	reg [8:0]  ctrl_r;
	reg [2:0]  status_r;
	reg [2:0]  irq_en_r;

	// Datapath state
	reg [OPND_W-1:0] a0_r;
	reg [OPND_W-1:0] b0_r;
	reg [OPND_W-1:0] a1_r;
	reg [OPND_W-1:0] b1_r;
	reg [PROD_W-1:0] p0_r;
	reg [PROD_W-1:0] p1_r;
	reg [PROD_W-1:0] res_r;
	reg              ovf_r;
	reg              ld_pend_r;
	reg [ACC_W-1:0]  init_r;

	wire [1:0] fn_sel;
	wire [1:0] wd_sel;
	wire       sgn;
	wire       in_reg_en;
	wire       pipe_en;
	wire       shift_en;
	wire       sub_en;
	wire       cfg_ok;

	assign fn_sel    = ctrl_r[`CTRL_FUNC_MSB:`CTRL_FUNC_LSB];
	assign wd_sel    = ctrl_r[`CTRL_WIDTH_MSB:`CTRL_WIDTH_LSB];
	assign sgn       = ctrl_r[`CTRL_SIGNED];
	assign in_reg_en = ctrl_r[`CTRL_IN_REG];
	assign pipe_en   = ctrl_r[`CTRL_PIPE_REG];
	assign shift_en  = ctrl_r[`CTRL_SHIFT];
	assign sub_en    = ctrl_r[`CTRL_SUB];
	assign cfg_ok    = count_at(fn_sel, wd_sel) != 4'h0;

	// AHB-Lite: zero wait states, always OKAY
	wire       take;
	wire       wr_ph;
	wire [2:0] clear_mask;

	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;
	assign take          = hsel_in & htrans_in[1] & hready_in;
	assign wr_ph         = ph_valid_r & ph_write_r;
	assign clear_mask    = (wr_ph && ph_addr_r == `OFS_CLEAR) ?
		hwdata_in[2:0] : 3'h0;

	always @(posedge clk_sys_in) begin
		if (srst_in) begin
			ph_valid_r <= 1'b0;
			ph_write_r <= 1'b0;
			ph_addr_r  <= 12'h000;
		end else if (ce_in) begin
			ph_valid_r <= take;
			ph_write_r <= hwrite_in;
			ph_addr_r  <= {haddr_in[11:2], 2'b00};
		end
	end

	always @(posedge clk_sys_in) begin
		if (srst_in) begin
			ctrl_r   <= `CTRL_RESET;
			irq_en_r <= 3'h0;
		end else if (ce_in && wr_ph) begin
			if (ph_addr_r == `OFS_CTRL)
				ctrl_r <= hwdata_in[`CTRL_W-1:0];
			else if (ph_addr_r == `OFS_IRQ_EN)
				irq_en_r <= hwdata_in[2:0];
		end
	end

	// Read data registered in the data phase
	always @(posedge clk_sys_in) begin
		if (srst_in) begin
			hrdata_out <= 32'h0000_0000;
		end else if (ce_in) begin
			if (!(take && !hwrite_in))
				hrdata_out <= 32'h0000_0000;
			else if (haddr_in[11:2] == `OFS_CTRL >> 2)
				hrdata_out <= {23'h000000, ctrl_r};
			else if (haddr_in[11:2] == `OFS_STATUS >> 2)
				hrdata_out <= {29'h00000000, status_r};
			else if (haddr_in[11:2] == `OFS_IRQ_EN >> 2)
				hrdata_out <= {29'h00000000, irq_en_r};
			else if (haddr_in[11:2] == `OFS_CAPACITY >> 2)
				hrdata_out <= {20'h00000, capacity(fn_sel)};
			else if (haddr_in[11:2] == `OFS_RES_LO >> 2)
				hrdata_out <= res_r[31:0];
			else if (haddr_in[11:2] == `OFS_RES_HI >> 2)
				hrdata_out <= res_r[63:32];
			else if (haddr_in[11:2] == `OFS_LIVE >> 2)
				hrdata_out <= {res_r[PROD_W-1:64], 21'h000000,
					cfg_ok, ovf_r, ld_pend_r};
			else
				hrdata_out <= 32'h0000_0000;
		end
	end

	// Operand registers: direct or shift chain, or bypass
	wire [OPND_W-1:0] src_a0;
	wire [OPND_W-1:0] src_b0;
	wire [OPND_W-1:0] src_a1;
	wire [OPND_W-1:0] src_b1;

	assign src_a0 = shift_en ? chain_a_in : opa0_in;
	assign src_b0 = shift_en ? chain_b_in : opb0_in;
	assign src_a1 = shift_en ? a0_r : opa1_in;
	assign src_b1 = shift_en ? b0_r : opb1_in;

	always @(posedge clk_sys_in) begin
		if (srst_in) begin
			a0_r <= {OPND_W{1'b0}};
			b0_r <= {OPND_W{1'b0}};
			a1_r <= {OPND_W{1'b0}};
			b1_r <= {OPND_W{1'b0}};
		end else if (ce_in) begin
			a0_r <= src_a0;
			b0_r <= src_b0;
			a1_r <= src_a1;
			b1_r <= src_b1;
		end
	end

	assign chain_a_out = a1_r;
	assign chain_b_out = b1_r;

	// Two product lanes
	wire [2*OPND_W-1:0] lane_a;
	wire [2*OPND_W-1:0] lane_b;
	wire [2*PROD_W-1:0] lane_p;

	assign lane_a = in_reg_en ? {a1_r, a0_r} : {src_a1, src_a0};
	assign lane_b = in_reg_en ? {b1_r, b0_r} : {src_b1, src_b0};

	genvar li;
	generate
		for (li = 0; li < 2; li = li + 1) begin : g_lane
			mac_product_lane #(
				.OPND_W (OPND_W),
				.PROD_W (PROD_W)
			) u_lane (
				.width_sel_in (wd_sel),
				.signed_in    (sgn),
				.opa_in       (lane_a[li*OPND_W +: OPND_W]),
				.opb_in       (lane_b[li*OPND_W +: OPND_W]),
				.prod_out     (lane_p[li*PROD_W +: PROD_W])
			);
		end
	endgenerate

	// Optional pipeline stage
	always @(posedge clk_sys_in) begin
		if (srst_in) begin
			p0_r <= {PROD_W{1'b0}};
			p1_r <= {PROD_W{1'b0}};
		end else if (ce_in) begin
			p0_r <= lane_p[PROD_W-1:0];
			p1_r <= lane_p[2*PROD_W-1:PROD_W];
		end
	end

	wire [PROD_W-1:0] p0;
	wire [PROD_W-1:0] p1;
	wire [PROD_W-1:0] pair;

	assign p0   = pipe_en ? p0_r : lane_p[PROD_W-1:0];
	assign p1   = pipe_en ? p1_r : lane_p[2*PROD_W-1:PROD_W];
	assign pair = sub_en ? p0 - p1 : p0 + p1;

	// Accumulator arithmetic with guard bits
	wire [SUM_W-1:0] acc_x;
	wire [SUM_W-1:0] addend;
	wire [SUM_W-1:0] total;
	wire             acc_mode;
	wire             total_ovf;

	assign acc_mode = fn_sel == `FN_ACCUM || fn_sel == `FN_SUM_ACCUM;
	assign acc_x    = {{2{sgn & res_r[ACC_W-1]}}, res_r[ACC_W-1:0]};
	assign addend   = fn_sel == `FN_ACCUM ? p0[SUM_W-1:0] :
		pair[SUM_W-1:0];
	assign total    = acc_x + addend;
	assign total_ovf = sgn ?
		(total[SUM_W-1:ACC_W-1] != {3{1'b0}} &&
		 total[SUM_W-1:ACC_W-1] != {3{1'b1}}) :
		(total[SUM_W-1:ACC_W] != 2'b00);

	// Load request waits for the next enabled edge
	always @(posedge clk_sys_in) begin
		if (srst_in) begin
			ld_pend_r <= 1'b0;
			init_r    <= {ACC_W{1'b0}};
		end else if (ce_in) begin
			ld_pend_r <= acc_load_in;
			if (acc_load_in)
				init_r <= acc_init_in;
		end
	end

	// Output register, always present
	reg [PROD_W-1:0] res_nxt;
	reg              ovf_nxt;

	always @* begin
		res_nxt = res_r;
		ovf_nxt = ovf_r;
		if (!cfg_ok) begin
			res_nxt = res_r;
		end else if (fn_sel == `FN_PRODUCT) begin
			res_nxt = p0;
			ovf_nxt = 1'b0;
		end else if (fn_sel == `FN_SUM_PROD) begin
			res_nxt = pair + chain_sum_in;
			ovf_nxt = 1'b0;
		end else if (ld_pend_r) begin
			res_nxt = {{(PROD_W-ACC_W){sgn & init_r[ACC_W-1]}},
				init_r};
			ovf_nxt = 1'b0;
		end else if (acc_mode) begin
			res_nxt = {{(PROD_W-ACC_W){sgn & total[ACC_W-1]}},
				total[ACC_W-1:0]};
			ovf_nxt = total_ovf;
		end
	end

	always @(posedge clk_sys_in) begin
		if (srst_in) begin
			res_r <= {PROD_W{1'b0}};
			ovf_r <= 1'b0;
		end else if (ce_in) begin
			res_r <= res_nxt;
			ovf_r <= ovf_nxt;
		end
	end

	assign result_out    = res_r;
	assign overflow_out  = ovf_r;
	assign chain_sum_out = res_r;

	// Sticky events, set wins over clear
	wire [2:0] ev;

	assign ev[`ST_OVERFLOW] = ovf_nxt & ~ovf_r & acc_mode & cfg_ok;
	assign ev[`ST_CFG_ERR]  = ~cfg_ok;
	assign ev[`ST_ACC_LOAD] = ld_pend_r & acc_mode & cfg_ok;

	always @(posedge clk_sys_in) begin
		if (srst_in)
			status_r <= 3'h0;
		else if (ce_in)
			status_r <= (status_r & ~clear_mask) | ev;
	end

	assign irq_out = |(status_r & irq_en_r);

endmodule
`default_nettype wire

/* tb/mac_slice_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module mac_slice_monitor #(
	parameter OPND_W = 36,
	parameter PROD_W = 72,
	parameter ACC_W  = 52
) (
	// Clock and reset
	input wire logic              clk_sys_in,
	input wire logic              srst_in,
	input wire logic              ce_in,
	// Bus
	input wire logic              hsel_in,
	input wire logic [31:0]       haddr_in,
	input wire logic [1:0]        htrans_in,
	input wire logic              hwrite_in,
	input wire logic [31:0]       hwdata_in,
	input wire logic              hready_in,
	input wire logic [31:0]       hrdata_out,
	input wire logic              hreadyout_out,
	input wire logic              hresp_out,
	// Datapath
	input wire logic [OPND_W-1:0] opa0_in,
	input wire logic [OPND_W-1:0] opb0_in,
	input wire logic              acc_load_in,
	input wire logic [ACC_W-1:0]  acc_init_in,
	input wire logic [OPND_W-1:0] chain_a_in,
	input wire logic [OPND_W-1:0] chain_a_out,
	input wire logic [PROD_W-1:0] result_out,
	input wire logic              overflow_out,
	input wire logic              irq_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);
	logic       wr_r;
	logic       rd_r;
	logic       rdc_r;
	logic [8:0] ctrl_r;
	wire        take = hsel_in & htrans_in[1] & hready_in;
	wire        at0  = haddr_in[11:2] == 10'h0;
	wire        prd  = ctrl_r[7:0] == 8'h0;
	wire        acc  = ctrl_r[1:0] == 2'h1 && !ctrl_r[3] && ctrl_r[6:5] == 2'h0;
	// Shadow of the control word
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			wr_r   <= 1'b0;
			rd_r   <= 1'b0;
			rdc_r  <= 1'b0;
			ctrl_r <= 9'h0;
		end else if (ce_in) begin
			wr_r  <= take & hwrite_in & at0;
			rd_r  <= take & !hwrite_in;
			rdc_r <= take & !hwrite_in & at0;
			if (wr_r) begin
				ctrl_r <= hwdata_in[8:0];
			end
		end
	end
	a_bus_okay: assert property (hreadyout_out && !hresp_out)
		else $error("bus answer not ready or not okay");
	a_reset_clear: assert property (disable iff (1'b0) srst_in && ce_in |=>
		result_out == '0 && !overflow_out && !irq_out && hrdata_out == 32'h0)
		else $error("outputs not cleared by reset");
	a_rdata_idle: assert property (!rd_r |-> hrdata_out == 32'h0)
		else $error("read data outside data phase");
	a_ctrl_read: assert property (rdc_r |-> hrdata_out == {23'h0, ctrl_r})
		else $error("control readback wrong");
	a_prod_latency: assert property (prd && ce_in ##1 ce_in |->
		result_out == PROD_W'($past(opa0_in[8:0])) * PROD_W'($past(opb0_in[8:0])))
		else $error("product not presented after one edge");
	a_load_init: assert property (acc && ce_in && acc_load_in && opa0_in == '0 ##1
		ce_in && !acc_load_in && opa0_in == '0 |=>
		result_out[ACC_W-1:0] == $past(acc_init_in, 2))
		else $error("accumulator not loaded");
	a_ovf_with_result: assert property (!$past(ce_in) |->
		$stable(overflow_out) && $stable(result_out))
		else $error("overflow or result moved while frozen");
	a_shift_chain: assert property (ctrl_r[7] && ce_in ##1 ctrl_r[7] && ce_in |=>
		chain_a_out == $past(chain_a_in, 2))
		else $error("shift chain wrong");
endmodule
bind mac_slice mac_slice_monitor #(
	.OPND_W(OPND_W),
	.PROD_W(PROD_W),
	.ACC_W (ACC_W)
) u_mon (.*);
`default_nettype wire

/* tb/fabric_user_model.sv */
`timescale 1ns/100ps
`default_nettype none
module fabric_user_model (
	// Clock
	input  wire logic        clk_sys_in,
	// Bench requests
	input  wire logic [35:0] a0_in,
	input  wire logic [35:0] b0_in,
	input  wire logic [35:0] a1_in,
	input  wire logic [35:0] b1_in,
	input  wire logic        load_req_in,
	input  wire logic [51:0] init_in,
	// Toward the slice
	output var  logic [35:0] opa0_out,
	output var  logic [35:0] opb0_out,
	output var  logic [35:0] opa1_out,
	output var  logic [35:0] opb1_out,
	output var  logic        acc_load_out,
	output var  logic [51:0] acc_init_out
);
	logic req_q;
	initial begin
		{opa0_out, opb0_out, opa1_out, opb1_out, acc_load_out, acc_init_out, req_q} = '0;
	end
	// Fabric flops; init value is garbage outside the load cycle
	always @(posedge clk_sys_in) begin
		opa0_out     <= a0_in;
		opb0_out     <= b0_in;
		opa1_out     <= a1_in;
		opb1_out     <= b1_in;
		req_q        <= load_req_in;
		acc_load_out <= load_req_in & ~req_q;
		acc_init_out <= (load_req_in & ~req_q) ? init_in : ~init_in;
	end
endmodule
`default_nettype wire

/* tb/tb_mac_slice.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_mac_slice;
	logic        clk_sys_in = 1'b0;
	logic        srst_in    = 1'b1;
	logic        ce_in      = 1'b1;
	logic [31:0] haddr_in   = 32'h0;
	logic [1:0]  htrans_in  = 2'h0;
	logic        hwrite_in  = 1'b0;
	logic [31:0] hwdata_in  = 32'h0;
	logic [35:0] a0 = 36'h0, b0 = 36'h0, a1 = 36'h0, b1 = 36'h0, ca = 36'h0, cb = 36'h0;
	logic [71:0] cs         = 72'h0;
	logic        ld         = 1'b0;
	logic [51:0] init       = 52'h0;
	logic [31:0] rv;
	logic [71:0] keep;
	wire  [35:0] opa0, opb0, opa1, opb1, ca_o, cb_o;
	wire  [71:0] res, cso;
	wire  [51:0] ini;
	wire  [31:0] hrdata;
	wire         hready, ldp, ovf, irq;
	int          failures    = 0;
	int          checks_done = 0;
	always #5 clk_sys_in = ~clk_sys_in;
	mac_slice dut (
		.clk_sys_in(clk_sys_in), .srst_in(srst_in), .ce_in(ce_in),
		.hsel_in(1'b1), .haddr_in(haddr_in), .htrans_in(htrans_in),
		.hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
		.hresp_out(), .opa0_in(opa0), .opb0_in(opb0), .opa1_in(opa1),
		.opb1_in(opb1), .acc_load_in(ldp), .acc_init_in(ini),
		.chain_a_in(ca), .chain_b_in(cb), .chain_sum_in(cs),
		.chain_a_out(ca_o), .chain_b_out(cb_o), .chain_sum_out(cso),
		.result_out(res), .overflow_out(ovf), .irq_out(irq)
	);
	fabric_user_model partner (
		.clk_sys_in(clk_sys_in), .a0_in(a0), .b0_in(b0), .a1_in(a1), .b1_in(b1),
		.load_req_in(ld), .init_in(init), .opa0_out(opa0), .opb0_out(opb0),
		.opa1_out(opa1), .opb1_out(opb1), .acc_load_out(ldp), .acc_init_out(ini)
	);
	task automatic stop_test();
		if (failures == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [71:0] s, input logic [71:0] e);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		haddr_in  <= a;
		hwrite_in <= w;
		htrans_in <= 2'h2;
		do @(posedge clk_sys_in); while (hready !== 1'b1);
		htrans_in <= 2'h0;
		hwdata_in <= d;
		do @(posedge clk_sys_in); while (hready !== 1'b1);
		rv = hrdata;
	endtask
	task automatic rdc(input logic [31:0] a, input logic [31:0] e, input string n);
		bus(1'b0, a, 32'h0);
		chk(n, rv, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic ops(input logic [35:0] a, input logic [35:0] b);
		@(posedge clk_sys_in);
		a0 <= a;
		b0 <= b;
	endtask
	task automatic load(input logic [51:0] v);
		@(posedge clk_sys_in);
		ld   <= 1'b1;
		init <= v;
		@(posedge clk_sys_in);
		ld <= 1'b0;
	endtask
	task automatic t_regs();
		logic [11:0] cap [4];
		cap = '{12'h841, 12'h220, 12'h420, 12'h210};
		rdc(32'h0, 32'h0, "ctrl");
		rdc(32'h4, 32'h0, "status");
		rdc(32'hc, 32'h0, "irq_en");
		bus(1'b1, 32'h20, 32'hffff_ffff);
		rdc(32'h20, 32'h0, "unmapped");
		for (int f = 0; f < 4; f++) begin
			bus(1'b1, 32'h0, 32'(f));
			rdc(32'h10, {20'h0, cap[f]}, "capacity");
		end
	endtask
	task automatic t_prod();
		bus(1'b1, 32'h0, 32'h0);
		ops(36'h1ff, 36'h1ff);
		tick(4);
		chk("prod9", res, 72'h3_fc01);
		bus(1'b1, 32'h0, 32'h14);
		ops(36'h3_fffd, 36'h5);
		tick(4);
		chk("prod18s", res, 72'hff_ffff_ffff_ffff_fff1);
		rdc(32'h14, 32'hffff_fff1, "res_lo");
		rdc(32'h18, 32'hffff_ffff, "res_hi");
		rdc(32'h1c, 32'hff00_0004, "live");
		bus(1'b1, 32'h0, 32'h64);
		tick(4);
		chk("prod18u", res, 72'h13_fff1);
		ops(36'h2, 36'h5);
		tick(3);
		chk("pipe_old", res, 72'h13_fff1);
		tick(1);
		chk("pipe_new", res, 72'ha);
		@(posedge clk_sys_in);
		ce_in <= 1'b0;
		a0    <= 36'h7;
		tick(6);
		chk("frozen", res, 72'ha);
		@(posedge clk_sys_in);
		ce_in <= 1'b1;
	endtask
	task automatic t_acc();
		ops(36'h0, 36'h0);
		bus(1'b1, 32'h0, 32'h15);
		bus(1'b1, 32'hc, 32'h4);
		load(52'h64);
		tick(4);
		chk("acc_init", res, 72'h64);
		chk("irq_on", irq, 1'b1);
		ops(36'h3_fffe, 36'h3);
		repeat (3) @(posedge clk_sys_in);
		a0 <= 36'h0;
		tick(4);
		chk("acc_sum", res, 72'h52);
		bus(1'b1, 32'hc, 32'h0);
		tick(1);
		chk("irq_mask", irq, 1'b0);
		bus(1'b1, 32'hc, 32'h4);
		bus(1'b1, 32'h8, 32'h4);
		tick(1);
		chk("irq_clr", irq, 1'b0);
		rdc(32'h4, 32'h0, "status_clr");
	endtask
	task automatic t_ovf();
		bus(1'b1, 32'h0, 32'h1);
		load(52'hf_ffff_ffff_ffff);
		tick(4);
		chk("ovf_low", ovf, 1'b0);
		ops(36'h1, 36'h1);
		@(posedge clk_sys_in);
		a0 <= 36'h0;
		tick(1);
		chk("ovf_high", ovf, 1'b1);
		chk("ovf_wrap", res, 72'h0);
		tick(1);
		chk("ovf_fall", ovf, 1'b0);
		rdc(32'h4, 32'h5, "status_ovf");
	endtask
	task automatic t_cfg();
		bus(1'b1, 32'h8, 32'h7);
		bus(1'b1, 32'h0, 32'h9);
		tick(2);
		keep = res;
		ops(36'h5, 36'h5);
		tick(4);
		chk("cfg_frozen", res, keep);
		rdc(32'h4, 32'h2, "status_cfg");
	endtask
	task automatic t_chain();
		@(posedge clk_sys_in);
		srst_in <= 1'b1;
		@(posedge clk_sys_in);
		srst_in <= 1'b0;
		rdc(32'h0, 32'h0, "ctrl_rst");
		bus(1'b1, 32'h0, 32'h80);
		@(posedge clk_sys_in);
		ca <= 36'h9_0123_4567;
		cb <= 36'h6_fedc_ba98;
		tick(3);
		chk("chain_a", ca_o, 36'h9_0123_4567);
		chk("chain_b", cb_o, 36'h6_fedc_ba98);
		bus(1'b1, 32'h0, 32'h2);
		ops(36'h3, 36'h4);
		a1 <= 36'h5;
		b1 <= 36'h6;
		cs <= 72'h64;
		tick(4);
		chk("sop_add", res, 72'h8e);
		chk("sop_chain", cso, 72'h8e);
		bus(1'b1, 32'h0, 32'h102);
		tick(4);
		chk("sop_sub", res, 72'h52);
		bus(1'b1, 32'h0, 32'h3);
		load(52'h10);
		tick(2);
		chk("sacc_init", res, 72'h10);
		tick(1);
		chk("sacc_step", res, 72'h3a);
	endtask
	initial begin
		repeat (2) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		t_regs();
		t_prod();
		t_acc();
		t_ovf();
		t_cfg();
		t_chain();
		stop_test();
	end
	initial begin
		repeat (5000) @(posedge clk_sys_in);
		failures++;
		stop_test();
	end
endmodule
`default_nettype wire
